// ---- design/cav_control.sv ----
// Purpose: register file, valley detector and calibration fields
// Assumes: comparator and amplifier analog results arrive synchronous
// Notes: all state lives in one packed struct
`timescale 1ns/10ps
module cav_control
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic [5:0] cmpRawIn,
  input wire logic [5:0] cmpDebIn,
  input wire logic ampOutIn,
  input wire logic irqTriggerIn,
  output logic cmp1NegSelect,
  output logic [1:0] cmp5NegSelect,
  output logic [39:0] cmpDacLevel,
  output logic [5:0] cmpPowerEnable,
  output logic [11:0] cmpHysteresisSelect,
  output logic [5:0] cmpOutputInvert,
  output logic [5:0] cmpCalibrationMode,
  output logic [4:0] cmpCalReferenceSelect,
  output logic [1:0] cmp0CalReferenceSelect,
  output logic [5:0] cmp0OffsetTrim,
  output logic [24:0] cmpOffsetTrim,
  output logic [5:0] cmpDebouncedOutput,
  output logic ampEnable,
  output logic [1:0] ampGainRatio,
  output logic ampCalibrationMode,
  output logic ampCalReferenceSelect,
  output logic [5:0] ampOffsetTrim,
  output logic [4:0] ampSwitchControl,
  output logic cmp3IrqSourceSelect,
  output logic blankingDoneStrobe,
  output logic cmp3ValleyResult,
  output logic cmp3Interrupt
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic cmp1Neg;
    logic [1:0] cmp5Neg;
    logic [4:0][7:0] dac;
    logic [7:0] blank;
    logic ampEn;
    logic [1:0] ampGain;
    logic ampStat;
    logic ampCalMode;
    logic ampCalRef;
    logic [5:0] ampTrim;
    logic [4:0] ampSw;
    logic [5:0] en;
    logic [5:0][1:0] hys;
    logic [5:0] inv;
    logic [5:0] calMode;
    logic [4:0] calRef;
    logic [1:0] cmp0Ref;
    logic [5:0] trim0;
    logic [4:0][4:0] trimN;
    logic [5:0] raw;
    logic [5:0] deb;
    logic busy;
    logic [6:0] cnt;
    logic done;
    logic valley;
    logic irq;
    logic [7:0] rdata;
  } cav_state_t;

  cav_state_t st_r;
  cav_state_t st_nxt;

  // load value for the blanking counter; strobe shows load+2 cycles
  // after the trigger cycle, i.e. a delay of load+1 clocks
  function automatic logic [6:0] blankLoad(input logic [5:0] code);
    logic [6:0] dly;
    dly = 7'h01;
    if (code > cav_pkg::BLANK_MAX_CODE)
    begin
      dly = cav_pkg::BLANK_SAT_DELAY;
    end
    else if (code != 6'h00)
    begin
      dly = 7'(cav_pkg::BLANK_STEP * 7'(code));
    end
    return 7'(dly - 7'h01);
  endfunction : blankLoad

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.done = 1'b0;
    st_nxt.valley = 1'b0;
    st_nxt.irq = 1'b0;
    // live status taken every cycle
    st_nxt.raw = cmpRawIn;
    st_nxt.deb = cmpDebIn ^ st_r.inv;
    // status only means something in calibration mode
    st_nxt.ampStat = st_r.ampCalMode & ampOutIn;

    // register writes; bit 4 of amp control is read only
    if (wrStb)
    begin
      unique case (addr)
        cav_pkg::ADDR_INSEL0:
        begin
          // reserved code 1 is never taken, so the pin stays routed
          st_nxt.cmp1Neg = 1'b0;
        end
        cav_pkg::ADDR_INSEL5:
        begin
          st_nxt.cmp5Neg = wrData[1:0];
        end
        cav_pkg::ADDR_BLANK:
        begin
          st_nxt.blank = wrData;
        end
        cav_pkg::ADDR_AMP_CTL:
        begin
          st_nxt.ampEn = wrData[cav_pkg::AMP_EN_BIT];
          st_nxt.ampGain = wrData[1:0];
        end
        cav_pkg::ADDR_AMP_CAL:
        begin
          st_nxt.ampCalMode = wrData[cav_pkg::AMP_CALM_BIT];
          st_nxt.ampCalRef = wrData[cav_pkg::AMP_CREF_BIT];
          st_nxt.ampTrim = wrData[5:0];
        end
        cav_pkg::ADDR_AMP_SW:
        begin
          st_nxt.ampSw = wrData[4:0];
        end
        default:
        begin
          st_nxt.blank = st_r.blank;
        end
      endcase
      // per-comparator registers share one layout each, except cmp0 in the cal and control registers
      for (int i = 0; i < 5; i++)
      begin
        if (addr == 8'(cav_pkg::ADDR_DAC_BASE + 8'(i)))
        begin
          st_nxt.dac[i] = wrData;
        end
      end
      for (int i = 0; i < 6; i++)
      begin
        if (addr == 8'(cav_pkg::ADDR_CAL_BASE + 8'(i)))
        begin
          st_nxt.calMode[i] = wrData[cav_pkg::CAL_MODE_BIT];
          if (i == 0)
          begin
            st_nxt.trim0 = wrData[5:0];
          end
          else
          begin
            st_nxt.calRef[i-1] = wrData[cav_pkg::CAL_REF_BIT];
            st_nxt.trimN[i-1] = wrData[4:0];
          end
        end
        if (addr == 8'(cav_pkg::ADDR_CTL_BASE + 8'(i)))
        begin
          st_nxt.en[i] = wrData[cav_pkg::CTL_EN_BIT];
          st_nxt.hys[i] = wrData[6:5];
          st_nxt.inv[i] = wrData[cav_pkg::CTL_INV_BIT];
          if (i == 0)
          begin
            st_nxt.cmp0Ref = wrData[1:0];
          end
        end
      end
    end

    // register reads; unmapped and reserved bits read zero
    if (rdStb)
    begin
      unique case (addr)
        cav_pkg::ADDR_INSEL0:
        begin
          st_nxt.rdata = {7'h00, st_r.cmp1Neg};
        end
        cav_pkg::ADDR_INSEL5:
        begin
          st_nxt.rdata = {6'h00, st_r.cmp5Neg};
        end
        cav_pkg::ADDR_BLANK:
        begin
          st_nxt.rdata = st_r.blank;
        end
        cav_pkg::ADDR_AMP_CTL:
        begin
          st_nxt.rdata = {st_r.ampEn, 2'h0, st_r.ampStat, 2'h0, st_r.ampGain};
        end
        cav_pkg::ADDR_AMP_CAL:
        begin
          st_nxt.rdata = {st_r.ampCalMode, st_r.ampCalRef, st_r.ampTrim};
        end
        cav_pkg::ADDR_AMP_SW:
        begin
          st_nxt.rdata = {3'h0, st_r.ampSw};
        end
        default:
        begin
          st_nxt.rdata = 8'h00;
        end
      endcase
      for (int i = 0; i < 5; i++)
      begin
        if (addr == 8'(cav_pkg::ADDR_DAC_BASE + 8'(i)))
        begin
          st_nxt.rdata = st_r.dac[i];
        end
      end
      for (int i = 0; i < 6; i++)
      begin
        if (addr == 8'(cav_pkg::ADDR_CAL_BASE + 8'(i)))
        begin
          if (i == 0)
          begin
            st_nxt.rdata = {st_r.raw[0], st_r.calMode[0], st_r.trim0};
          end
          else
          begin
            st_nxt.rdata = {st_r.raw[i], st_r.calMode[i], st_r.calRef[i-1],
                            st_r.trimN[i-1]};
          end
        end
        if (addr == 8'(cav_pkg::ADDR_CTL_BASE + 8'(i)))
        begin
          st_nxt.rdata = {st_r.en[i], st_r.hys[i], st_r.deb[i], st_r.inv[i],
                          1'b0, (i == 0) ? st_r.cmp0Ref : 2'h0};
        end
      end
    end

    // blanking counter; a trigger while busy is ignored so one
    // strobe answers one trigger
    if (st_r.busy)
    begin
      if (st_r.cnt == 7'h00)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        // sample once; match against the inversion setting
        st_nxt.valley = (st_r.deb[3] == st_r.inv[3]);
      end
      else
      begin
        st_nxt.cnt = 7'(st_r.cnt - 7'h01);
      end
    end
    else if (irqTriggerIn && st_r.blank[cav_pkg::BLK_EN_BIT])
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = blankLoad(st_r.blank[5:0]);
    end

    // interrupt source: valley pulse or rising debounced output
    if (st_r.blank[cav_pkg::BLK_SRC_BIT])
    begin
      st_nxt.irq = st_nxt.valley;
    end
    else
    begin
      st_nxt.irq = st_nxt.deb[3] & ~st_r.deb[3];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.dac <= {5{cav_pkg::DAC_RST}};
      st_r.ampTrim <= cav_pkg::AMP_TRIM_RST;
      st_r.trim0 <= cav_pkg::CMP0_TRIM_RST;
      st_r.trimN <= {5{cav_pkg::CMPN_TRIM_RST}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign rdData = st_r.rdata;
  assign cmp1NegSelect = st_r.cmp1Neg;
  assign cmp5NegSelect = st_r.cmp5Neg;
  assign cmpDacLevel = st_r.dac;
  assign cmpPowerEnable = st_r.en;
  assign cmpHysteresisSelect = st_r.hys;
  assign cmpOutputInvert = st_r.inv;
  assign cmpCalibrationMode = st_r.calMode;
  assign cmpCalReferenceSelect = st_r.calRef;
  assign cmp0CalReferenceSelect = st_r.cmp0Ref;
  assign cmp0OffsetTrim = st_r.trim0;
  assign cmpOffsetTrim = st_r.trimN;
  assign cmpDebouncedOutput = st_r.deb;
  assign ampEnable = st_r.ampEn;
  assign ampGainRatio = st_r.ampGain;
  assign ampCalibrationMode = st_r.ampCalMode;
  assign ampCalReferenceSelect = st_r.ampCalRef;
  assign ampOffsetTrim = st_r.ampTrim;
  assign ampSwitchControl = st_r.ampSw;
  assign cmp3IrqSourceSelect = st_r.blank[cav_pkg::BLK_SRC_BIT];
  assign blankingDoneStrobe = st_r.done;
  assign cmp3ValleyResult = st_r.valley;
  assign cmp3Interrupt = st_r.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // accepted trigger, used by the delay checks
  logic trigTaken;
  assign trigTaken = irqTriggerIn & st_r.blank[cav_pkg::BLK_EN_BIT] & ~st_r.busy;

  bypass_delay_a : assert property (@(posedge clk_sys) disable iff (rst)
    (trigTaken && st_r.blank[5:0] == 6'h00) |-> ##1 !blankingDoneStrobe ##1 blankingDoneStrobe)
    else $error("bypass blanking delay wrong");

  step_delay_a : assert property (@(posedge clk_sys) disable iff (rst)
    (trigTaken && st_r.blank[5:0] == 6'h05) |-> ##1 !blankingDoneStrobe [*8] ##3 blankingDoneStrobe)
    else $error("coded blanking delay wrong");

  sat_delay_a : assert property (@(posedge clk_sys) disable iff (rst)
    (trigTaken && st_r.blank[5:4] == 2'h3) |-> ##96 blankingDoneStrobe)
    else $error("saturated blanking delay wrong");

  valley_low_a : assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.busy && st_r.cnt == 7'h00 && !st_r.inv[3])
      |=> (cmp3ValleyResult == !$past(st_r.deb[3])))
    else $error("valley result wrong when not inverted");

  valley_high_a : assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.busy && st_r.cnt == 7'h00 && st_r.inv[3])
      |=> (cmp3ValleyResult == $past(st_r.deb[3])))
    else $error("valley result wrong when inverted");

  valley_once_a : assert property (@(posedge clk_sys) disable iff (rst)
    cmp3ValleyResult |-> blankingDoneStrobe ##1 !cmp3ValleyResult)
    else $error("valley pulse not single or unstrobed");

  irq_source_a : assert property (@(posedge clk_sys) disable iff (rst)
    ($past(!rst) && $past(st_r.blank[cav_pkg::BLK_SRC_BIT]))
      |-> (cmp3Interrupt == cmp3ValleyResult))
    else $error("valley source not routed to interrupt");

  dac_write_a : assert property (@(posedge clk_sys) disable iff (rst)
    (wrStb && addr == cav_pkg::ADDR_DAC_BASE) |=> (cmpDacLevel[7:0] == $past(wrData)))
    else $error("dac code not stored");

  amp_status_a : assert property (@(posedge clk_sys) disable iff (rst)
    (rdStb && addr == cav_pkg::ADDR_AMP_CTL && !ampCalibrationMode && !$past(ampCalibrationMode))
      |=> !rdData[cav_pkg::AMP_STAT_BIT])
    else $error("amp status visible outside calibration");

  deb_invert_a : assert property (@(posedge clk_sys) disable iff (rst)
    $past(!rst) |-> (cmpDebouncedOutput == $past(cmpDebIn ^ st_r.inv)))
    else $error("debounced output inversion wrong");

  raw_read_a : assert property (@(posedge clk_sys) disable iff (rst)
    ($past(!rst) && rdStb && addr == cav_pkg::ADDR_CAL_BASE)
      |=> (rdData[cav_pkg::CAL_RAW_BIT] == $past(cmpRawIn[0], 2)))
    else $error("raw output read wrong");

  cmp1_route_a : assert property (@(posedge clk_sys) disable iff (rst)
    !cmp1NegSelect)
    else $error("cmp1 reserved select taken");

endmodule : cav_control

// ---- design/cav_pkg.sv ----
// Purpose: constants of the comparator and amplifier control block
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: register offsets are byte addresses on the plain port
// Operation
// - cmp1 negative input routes cmp0 positive pin
// - cmp5 negative select picks one of four
// - DAC code register, output code/256, reset zero
// - cmp3 irq source: debounced or valley
// - blanking delay code sets delay in clocks
// - valid trigger with enable gives blanking-done strobe
// - non-inverted: irq when sampled output is 0
// - inverted: irq when sampled output is 1
// - offset trim: 6 bits cmp0, 5 others
// - amplifier enable bit 7, reset disabled
// - read-only amplifier status in cal mode
// - gain field selects ratio 20/30/40/60
// - amplifier mode bit: normal or calibration
// - amplifier cal reference: inverting or non-inverting
// - amplifier 6-bit trim resets to 100000
// - raw comparator output readable per comparator
// - debounced output, inverted when invert set
package cav_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_INSEL0 = 8'h00;
  localparam logic [7:0] ADDR_INSEL5 = 8'h01;
  localparam logic [7:0] ADDR_DAC_BASE = 8'h02;
  localparam logic [7:0] ADDR_BLANK = 8'h07;
  localparam logic [7:0] ADDR_AMP_CTL = 8'h08;
  localparam logic [7:0] ADDR_AMP_CAL = 8'h09;
  localparam logic [7:0] ADDR_AMP_SW = 8'h0A;
  localparam logic [7:0] ADDR_CAL_BASE = 8'h0B;
  localparam logic [7:0] ADDR_CTL_BASE = 8'h11;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BLK_EN_BIT = 7;
  localparam int BLK_SRC_BIT = 6;
  localparam int AMP_EN_BIT = 7;
  localparam int AMP_STAT_BIT = 4;
  localparam int AMP_CALM_BIT = 7;
  localparam int AMP_CREF_BIT = 6;
  localparam int CAL_RAW_BIT = 7;
  localparam int CAL_MODE_BIT = 6;
  localparam int CAL_REF_BIT = 5;
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_DEB_BIT = 4;
  localparam int CTL_INV_BIT = 3;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [5:0] AMP_TRIM_RST = 6'h20;
  localparam logic [5:0] CMP0_TRIM_RST = 6'h20;
  localparam logic [4:0] CMPN_TRIM_RST = 5'h10;
  localparam logic [7:0] DAC_RST = 8'h00;
  localparam logic [6:0] BLANK_STEP = 7'h02;
  localparam logic [6:0] BLANK_SAT_DELAY = 7'h5F;
  localparam logic [5:0] BLANK_MAX_CODE = 6'h2F;
endpackage : cav_pkg

// ---- tb/cav_control_test.sv ----
// Purpose: register-level bench for the comparator and amplifier control block
// Assumes: read data stand one cycle after the read strobe
// Notes: valley timing is counted in cycles from the trigger cycle
`timescale 1ns/10ps
module cav_control_test;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'h0;
  logic rdStb = 1'h0;
  logic [7:0] rdData;
  logic [5:0] cmpRawIn = 6'h00;
  logic [5:0] cmpDebIn = 6'h00;
  logic ampOutIn = 1'h0;
  logic irqTriggerIn = 1'h0;
  logic cmp1NegSelect, ampEnable, ampCalibrationMode, ampCalReferenceSelect;
  logic cmp3IrqSourceSelect, blankingDoneStrobe, cmp3ValleyResult, cmp3Interrupt;
  logic [1:0] cmp5NegSelect, cmp0CalReferenceSelect, ampGainRatio;
  logic [39:0] cmpDacLevel;
  logic [5:0] cmpPowerEnable, cmpOutputInvert, cmpCalibrationMode, cmp0OffsetTrim;
  logic [5:0] cmpDebouncedOutput, ampOffsetTrim;
  logic [11:0] cmpHysteresisSelect;
  logic [4:0] cmpCalReferenceSelect, ampSwitchControl;
  logic [24:0] cmpOffsetTrim;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rv;
  int vUp = 0;
  int vDown = 0;

  cav_control cav_control_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .cmpRawIn(cmpRawIn), .cmpDebIn(cmpDebIn),
    .ampOutIn(ampOutIn), .irqTriggerIn(irqTriggerIn), .cmp1NegSelect(cmp1NegSelect),
    .cmp5NegSelect(cmp5NegSelect), .cmpDacLevel(cmpDacLevel), .cmpPowerEnable(cmpPowerEnable),
    .cmpHysteresisSelect(cmpHysteresisSelect), .cmpOutputInvert(cmpOutputInvert),
    .cmpCalibrationMode(cmpCalibrationMode), .cmpCalReferenceSelect(cmpCalReferenceSelect),
    .cmp0CalReferenceSelect(cmp0CalReferenceSelect), .cmp0OffsetTrim(cmp0OffsetTrim),
    .cmpOffsetTrim(cmpOffsetTrim), .cmpDebouncedOutput(cmpDebouncedOutput),
    .ampEnable(ampEnable), .ampGainRatio(ampGainRatio), .ampCalibrationMode(ampCalibrationMode),
    .ampCalReferenceSelect(ampCalReferenceSelect), .ampOffsetTrim(ampOffsetTrim),
    .ampSwitchControl(ampSwitchControl), .cmp3IrqSourceSelect(cmp3IrqSourceSelect),
    .blankingDoneStrobe(blankingDoneStrobe), .cmp3ValleyResult(cmp3ValleyResult),
    .cmp3Interrupt(cmp3Interrupt));

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task close_out;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : close_out

  task chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask : chk

  // one-cycle write, fields settle after the taking edge
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge clk_sys);
    wrStb <= 1'h0;
    #1;
  end
  endtask : wr

  // read data are taken in the single cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge clk_sys);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge clk_sys);
    rdStb <= 1'h0;
    #1;
    d = rdData;
  end
  endtask : rd

  task rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
  begin
    rd(a, rv);
    chk(name, {32'h0, rv}, {32'h0, exp});
  end
  endtask : rdchk

  // one-cycle trigger, then count cycles until the blanking strobe
  task valley(input logic [5:0] code, input logic inv, input logic deb, input int expN);
    int n;
    logic exv;
  begin
    exv = ((deb ^ inv) == inv);
    wr(cav_pkg::ADDR_CTL_BASE + 8'h03, {4'h0, inv, 3'h0});
    cmpDebIn <= {2'h0, deb, 3'h0};
    wr(cav_pkg::ADDR_BLANK, {2'h3, code});
    @(posedge clk_sys);
    irqTriggerIn <= 1'h1;
    @(posedge clk_sys);
    irqTriggerIn <= 1'h0;
    n = 1;
    #1;
    while (blankingDoneStrobe !== 1'h1 && n < 120)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("strobe delay", 40'(n), 40'(expN));
    chk("valley", {39'h0, cmp3ValleyResult}, {39'h0, exv});
    chk("irq", {39'h0, cmp3Interrupt}, {39'h0, exv});
    @(posedge clk_sys);
    #1;
    chk("strobe single", {39'h0, blankingDoneStrobe | cmp3Interrupt}, 40'h0);
  end
  endtask : valley

  // hang guard: the whole run needs well under 5000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out;
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    #1;
    chk("amp trim rst", {34'h0, ampOffsetTrim}, 40'h20);
    chk("cmp trim rst", {15'h0, cmpOffsetTrim}, {15'h0, {5{5'h10}}});
    for (int i = 0; i < 5; i++)
      rdchk("dac rst", cav_pkg::ADDR_DAC_BASE + 8'(i), 8'h00);
    rdchk("blank rst", cav_pkg::ADDR_BLANK, 8'h00);
    rdchk("ampctl rst", cav_pkg::ADDR_AMP_CTL, 8'h00);
    rdchk("ampcal rst", cav_pkg::ADDR_AMP_CAL, 8'h20);
    rdchk("cmp0 cal rst", cav_pkg::ADDR_CAL_BASE, 8'h20);
    $display("test reset done");
    // reserved select code and unmapped place
    wr(cav_pkg::ADDR_INSEL0, 8'h01);
    chk("cmp1 sel", {39'h0, cmp1NegSelect}, 40'h0);
    rdchk("cmp1 sel rd", cav_pkg::ADDR_INSEL0, 8'h00);
    wr(8'h40, 8'hFF);
    rdchk("unmapped", 8'h40, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(cav_pkg::ADDR_INSEL5, 8'(i));
      chk("cmp5 sel", {38'h0, cmp5NegSelect}, 40'(i));
      rdchk("cmp5 sel rd", cav_pkg::ADDR_INSEL5, 8'(i));
    end
    for (int i = 0; i < 5; i++)
      wr(cav_pkg::ADDR_DAC_BASE + 8'(i), 8'hA1 + 8'(i));
    chk("dac codes", cmpDacLevel, 40'hA5A4A3A2A1);
    $display("test selects done");
    // amplifier fields
    for (int i = 0; i < 4; i++)
    begin
      wr(cav_pkg::ADDR_AMP_CTL, 8'h90 | 8'(i));
      chk("gain", {38'h0, ampGainRatio}, 40'(i));
      rdchk("ampctl rd", cav_pkg::ADDR_AMP_CTL, 8'h80 | 8'(i));
    end
    chk("amp en", {39'h0, ampEnable}, 40'h1);
    ampOutIn <= 1'h1;
    wr(cav_pkg::ADDR_AMP_CAL, 8'hC5);
    chk("amp cal", {32'h0, ampCalibrationMode, ampCalReferenceSelect, ampOffsetTrim},
      40'hC5);
    rdchk("amp status 1", cav_pkg::ADDR_AMP_CTL, 8'h93);
    ampOutIn <= 1'h0;
    rdchk("amp status 0", cav_pkg::ADDR_AMP_CTL, 8'h83);
    wr(cav_pkg::ADDR_AMP_SW, 8'hFF);
    rdchk("amp sw", cav_pkg::ADDR_AMP_SW, 8'h1F);
    chk("amp sw out", {35'h0, ampSwitchControl}, 40'h1F);
    $display("test amplifier done");
    // calibration trims, raw and debounced status
    cmpRawIn <= 6'h01;
    cmpDebIn <= 6'h04;
    wr(cav_pkg::ADDR_CAL_BASE, 8'h7F);
    chk("cmp0 trim", {34'h0, cmp0OffsetTrim}, 40'h3F);
    wr(cav_pkg::ADDR_CAL_BASE + 8'h01, 8'h7F);
    chk("cmp1 trim", {35'h0, cmpOffsetTrim[4:0]}, 40'h1F);
    rdchk("cmp0 raw", cav_pkg::ADDR_CAL_BASE, 8'hFF);
    rdchk("cmp1 raw", cav_pkg::ADDR_CAL_BASE + 8'h01, 8'h7F);
    wr(cav_pkg::ADDR_CTL_BASE, 8'h83);
    rdchk("cmp0 ctl", cav_pkg::ADDR_CTL_BASE, 8'h83);
    rdchk("cmp2 deb", cav_pkg::ADDR_CTL_BASE + 8'h02, 8'h10);
    wr(cav_pkg::ADDR_CTL_BASE + 8'h02, 8'h08);
    // the debounced copy takes the new invert one cycle later
    @(posedge clk_sys);
    #1;
    chk("deb inv", {39'h0, cmpDebouncedOutput[2]}, 40'h0);
    rdchk("cmp2 deb inv", cav_pkg::ADDR_CTL_BASE + 8'h02, 8'h08);
    // offset sweep on cmp1; the bench plays the analog side, flipping above trim 12
    wr(cav_pkg::ADDR_CTL_BASE + 8'h01, 8'h80);
    for (int t = 0; t < 32; t++)
    begin
      wr(cav_pkg::ADDR_CAL_BASE + 8'h01, 8'h60 | 8'(t));
      cmpRawIn <= {4'h0, 1'(t > 12), 1'h0};
      rd(cav_pkg::ADDR_CAL_BASE + 8'h01, rv);
      if (rv[7] === 1'h1)
      begin
        vUp = t;
        break;
      end
    end
    for (int t = 31; t >= 0; t--)
    begin
      wr(cav_pkg::ADDR_CAL_BASE + 8'h01, 8'h60 | 8'(t));
      cmpRawIn <= {4'h0, 1'(t > 12), 1'h0};
      rd(cav_pkg::ADDR_CAL_BASE + 8'h01, rv);
      if (rv[7] === 1'h0)
      begin
        vDown = t;
        break;
      end
    end
    // mean of both ends, fraction dropped
    wr(cav_pkg::ADDR_CAL_BASE + 8'h01, 8'h60 | 8'((vUp + vDown) / 2));
    chk("cal up", 40'(vUp), 40'hD);
    chk("cal down", 40'(vDown), 40'hC);
    chk("cal trim", {35'h0, cmpOffsetTrim[4:0]}, 40'hC);
    $display("test calibration done");
    // valley detector over delay codes and sample levels
    valley(6'h00, 1'h0, 1'h0, 2);
    valley(6'h01, 1'h0, 1'h1, 3);
    valley(6'h02, 1'h1, 1'h0, 5);
    valley(6'h05, 1'h0, 1'h1, 11);
    valley(6'h2F, 1'h1, 1'h1, 95);
    valley(6'h30, 1'h0, 1'h0, 96);
    valley(6'h3F, 1'h0, 1'h0, 96);
    // detector disabled: trigger ignored
    wr(cav_pkg::ADDR_BLANK, 8'h40);
    @(posedge clk_sys);
    irqTriggerIn <= 1'h1;
    @(posedge clk_sys);
    irqTriggerIn <= 1'h0;
    rv = 8'h00;
    repeat (6)
    begin
      @(posedge clk_sys);
      #1;
      rv = rv | {7'h0, blankingDoneStrobe};
    end
    chk("disabled", {32'h0, rv}, 40'h0);
    // source 0: interrupt follows the debounced output rising
    wr(cav_pkg::ADDR_BLANK, 8'h80);
    wr(cav_pkg::ADDR_CTL_BASE + 8'h03, 8'h00);
    chk("src sel", {39'h0, cmp3IrqSourceSelect}, 40'h0);
    cmpDebIn <= 6'h08;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1;
      if (cmpDebouncedOutput[3] === 1'h1)
        break;
    end
    chk("deb irq", {39'h0, cmp3Interrupt}, 40'h1);
    @(posedge clk_sys);
    #1;
    chk("deb irq end", {39'h0, cmp3Interrupt}, 40'h0);
    $display("test valley done");
    close_out;
  end
endmodule : cav_control_test
